// >>> logic/rths_consts.svh
`ifndef RTHS_CONSTS_SVH
`define RTHS_CONSTS_SVH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define RTHS_OFS_CTRL 12'h000
`define RTHS_OFS_MODE 12'h004
`define RTHS_OFS_RUN_SPD 12'h008
`define RTHS_OFS_ACCEL 12'h00C
`define RTHS_OFS_START_SPD 12'h010
`define RTHS_OFS_OFFSET 12'h014
`define RTHS_OFS_PRESET 12'h018
`define RTHS_OFS_PUSH_CUR 12'h01C
`define RTHS_OFS_STATUS 12'h020
`define RTHS_OFS_CMD_POS 12'h024
`define RTHS_OFS_APPROACH 12'h028
// ----------------------------------------
// field positions
// ----------------------------------------
`define RTHS_CTRL_DIR_BIT 0
`define RTHS_CTRL_QUALIFY_IN_A_BIT 1
`define RTHS_CTRL_TIM_BIT 2
`define RTHS_CTRL_PRESET_BIT 3
`define RTHS_ST_READY_BIT 0
`define RTHS_ST_MOVING_BIT 1
`define RTHS_ST_DONE_BIT 2
// ----------------------------------------
// reset values and limits
// ----------------------------------------
`define RTHS_MODE_TWO 2'h0
`define RTHS_MODE_THREE 2'h1
`define RTHS_MODE_PUSH 2'h2
`define RTHS_RST_RUN_SPD 20'h003E8
`define RTHS_RST_ACCEL 20'h003E8
`define RTHS_RST_START_SPD 20'h001F4
`define RTHS_RST_PUSH_CUR 10'h3E8
`define RTHS_RST_DIR 1'b1
`define RTHS_SPD_MIN 20'h00001
`define RTHS_SPD_MAX 20'hF4240
`define RTHS_CUR_MAX 10'h3E8
`define RTHS_APPROACH_CAP 20'h001F4
`define RTHS_ESCAPE_STEPS 24'h0000C8
`endif

// >>> logic/rths_pkg.sv
package rths_pkg;
  typedef enum logic [2:0] {
    RTHS_IDLE = 3'h0,
    RTHS_SEEK = 3'h1,
    RTHS_QUAL = 3'h3,
    RTHS_ESCAPE = 3'h2,
    RTHS_WALK = 3'h6,
    RTHS_OFFSET = 3'h7,
    RTHS_DONE = 3'h5
  } rths_state_e;

  typedef struct packed {
    logic dir_pos;
    logic qualify_in_a_en;
    logic tim_en;
    logic [1:0] mode;
    logic [19:0] run_spd;
    logic [19:0] accel;
    logic [19:0] start_spd;
    logic [23:0] offset;
    logic [23:0] preset;
    logic [9:0] push_cur;
  } rths_cfg_s;

  typedef struct packed {
    logic ready;
    logic moving;
    logic home_done;
  } rths_stat_s;

  // command to the motion-profile generator
  typedef struct packed {
    logic run;
    logic dir_pos;
    logic [19:0] speed;
    logic [23:0] steps;
    logic by_steps;
    logic push;
  } rths_motion_s;
endpackage

// >>> logic/rths_cfg_regs.sv
`timescale 1ns/1ps
`include "rths_consts.svh"
module rths_cfg_regs (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic wr_en,
  input wire logic [11:0] wr_addr,
  input wire logic [31:0] wr_data,
  output rths_pkg::rths_cfg_s cfg,
  output logic wr_ok
);
  typedef struct packed {
    rths_pkg::rths_cfg_s cfg;
  } rths_cr_state_s;

  rths_cr_state_s s_q;
  rths_cr_state_s s_d;

  // ----------------------------------------
  // range-checked parameter writes
  // ----------------------------------------
  // an out-of-range value is dropped so the seek never runs at zero speed
  function automatic logic spd_ok(input logic [31:0] v);
    spd_ok = (v[31:20] == 12'h000) && (v[19:0] >= `RTHS_SPD_MIN) && (v[19:0] <= `RTHS_SPD_MAX);
  endfunction

  always_comb begin
    s_d = s_q;
    wr_ok = 1'b1;
    if (wr_en) begin
      unique case (wr_addr)
        `RTHS_OFS_CTRL: begin
          s_d.cfg.dir_pos = wr_data[`RTHS_CTRL_DIR_BIT]; // RL10
          s_d.cfg.qualify_in_a_en = wr_data[`RTHS_CTRL_QUALIFY_IN_A_BIT]; // RL11
          s_d.cfg.tim_en = wr_data[`RTHS_CTRL_TIM_BIT]; // RL12
        end
        `RTHS_OFS_MODE: begin
          if (wr_data[1:0] <= `RTHS_MODE_PUSH) begin
            s_d.cfg.mode = wr_data[1:0]; // RL5
          end
          else begin
            wr_ok = 1'b0;
          end
        end
        `RTHS_OFS_RUN_SPD: begin
          if (spd_ok(wr_data)) s_d.cfg.run_spd = wr_data[19:0]; // RL6
          else wr_ok = 1'b0;
        end
        `RTHS_OFS_ACCEL: begin
          if (spd_ok(wr_data)) s_d.cfg.accel = wr_data[19:0]; // RL7
          else wr_ok = 1'b0;
        end
        `RTHS_OFS_START_SPD: begin
          if (spd_ok(wr_data)) s_d.cfg.start_spd = wr_data[19:0]; // RL8
          else wr_ok = 1'b0;
        end
        `RTHS_OFS_OFFSET: s_d.cfg.offset = wr_data[23:0]; // RL9
        `RTHS_OFS_PRESET: s_d.cfg.preset = wr_data[23:0];
        `RTHS_OFS_PUSH_CUR: begin
          if (wr_data[31:10] == 22'h000000 && wr_data[9:0] <= `RTHS_CUR_MAX) s_d.cfg.push_cur = wr_data[9:0]; // RL13
          else wr_ok = 1'b0;
        end
        default: wr_ok = 1'b0;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q.cfg.dir_pos <= `RTHS_RST_DIR;
      s_q.cfg.qualify_in_a_en <= 1'b0;
      s_q.cfg.tim_en <= 1'b0;
      s_q.cfg.mode <= `RTHS_MODE_TWO;
      s_q.cfg.run_spd <= `RTHS_RST_RUN_SPD;
      s_q.cfg.accel <= `RTHS_RST_ACCEL;
      s_q.cfg.start_spd <= `RTHS_RST_START_SPD;
      s_q.cfg.offset <= 24'h000000;
      s_q.cfg.preset <= 24'h000000;
      s_q.cfg.push_cur <= `RTHS_RST_PUSH_CUR;
    end
    else begin
      s_q <= s_d;
    end
  end

  assign cfg = s_q.cfg;
endmodule

// >>> logic/rths_top.sv
// Added by the designer: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "rths_consts.svh"
// What this block does
// RL1: sensor or push homing ends with an offset move; its stop is electrical home.
// RL2: zero offset means no offset move; electrical home equals mechanical home.
// RL3: after two-sensor, three-sensor or push homing, command position becomes zero.
// RL4: preset while stopped loads preset position; no offset, no qualification.
// RL5: mode 0 two-sensor, 1 three-sensor, 2 push.
// RL6: run speed 1 to 1,000,000 Hz, default 1,000.
// RL7: acceleration setting 1 to 1,000,000, default 1,000.
// RL8: start speed 1 to 1,000,000 Hz, default 500.
// RL9: home offset signed -8,388,608 to 8,388,607, default zero.
// RL10: direction 0 negative, 1 positive, default 1.
// RL11: qualify_in_a qualification enable, default off.
// RL12: step-timing qualification enable, default off.
// RL13: push current 0 to 1,000 in 0.1 percent units, default 1,000.
// RL14: with step timing in use, resolution should be a multiple of 50.
// RL15: host waits for ready before raising home request.
// RL16: home request starts homing, drops ready, raises moving.
// RL17: host holds home request until ready drops, then releases it.
// RL18: completed homing raises home-complete.
// RL19: optional qualify_in_a and step-timing qualification refine home detection.
// RL20: after origin sensor rises, finish only on qualifier while sensor still active.
// RL21: three-sensor mode seeks at run speed, stops on origin sensor.
// RL22: two-sensor mode reverses at limit, escapes, moves 200 steps, stops.
// RL23: final approach speed is start speed if under 500 Hz, else 500 Hz.
// RL24: ready returns and moving drops once everything including offset is done.
module rths_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic home_req,
  input wire logic origin_sensor_in,
  input wire logic qualify_in_a,
  input wire logic step_timing_signal,
  input wire logic negative_limit_sensor,
  input wire logic positive_limit_sensor,
  input wire logic push_stall,
  input wire logic motion_done,
  output logic ready,
  output logic moving,
  output logic home_done,
  output rths_pkg::rths_motion_s motion,
  output logic [9:0] push_current,
  output logic [19:0] accel_rate,
  output logic [23:0] cmd_pos
);
  typedef struct packed {
    rths_pkg::rths_state_e st;
    rths_pkg::rths_stat_s stat;
    rths_pkg::rths_motion_s motion;
    logic [23:0] cmd_pos;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic origin_prev;
    logic [9:0] push_current;
    logic [19:0] accel_rate;
  } rths_state_s;

  rths_state_s s_q;
  rths_state_s s_d;
  rths_pkg::rths_cfg_s cfg;
  logic wr_ok;
  logic bus_wr;
  logic [19:0] approach;
  logic qual_hit;
  logic limit_hit;
  logic origin_rise;

  // ----------------------------------------
  // configuration store
  // ----------------------------------------
  assign bus_wr = psel && penable && pwrite && !s_q.pready;

  rths_cfg_regs u_cfg (
    .pclk(pclk),
    .presetn(presetn),
    .wr_en(bus_wr && s_q.stat.ready),
    .wr_addr(paddr),
    .wr_data(pwdata),
    .cfg(cfg),
    .wr_ok(wr_ok)
  );

  // ----------------------------------------
  // derived terms
  // ----------------------------------------
  assign approach = (cfg.start_spd < `RTHS_APPROACH_CAP) ? cfg.start_spd : `RTHS_APPROACH_CAP; // RL23
  // the qualifier only counts while the origin sensor is still on
  assign qual_hit = origin_sensor_in && (!cfg.qualify_in_a_en || qualify_in_a)
                    && (!cfg.tim_en || step_timing_signal); // RL19 RL20
  assign limit_hit = s_q.motion.dir_pos ? positive_limit_sensor : negative_limit_sensor;
  assign origin_rise = origin_sensor_in && !s_q.origin_prev;

  // ----------------------------------------
  // sequencer and bus answer
  // ----------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.origin_prev = origin_sensor_in;
    s_d.pready = 1'b0;
    s_d.pslverr = 1'b0;
    s_d.push_current = cfg.push_cur; // RL13
    s_d.accel_rate = cfg.accel; // RL7
    // one wait state: pready rises in the second access cycle
    if (psel && penable && !s_q.pready) begin
      s_d.pready = 1'b1;
      s_d.prdata = 32'h00000000;
      if (pwrite) begin
        if (paddr == `RTHS_OFS_CTRL && pwdata[`RTHS_CTRL_PRESET_BIT]) begin
          if (s_q.stat.ready) begin
            s_d.cmd_pos = cfg.preset; // RL4
          end
          else begin
            s_d.pslverr = 1'b1;
          end
        end
        else if (!s_q.stat.ready || !wr_ok) begin
          s_d.pslverr = 1'b1;
        end
      end
      else begin
        unique case (paddr)
          `RTHS_OFS_CTRL: s_d.prdata = {29'h00000000, cfg.tim_en, cfg.qualify_in_a_en, cfg.dir_pos};
          `RTHS_OFS_MODE: s_d.prdata = {30'h00000000, cfg.mode};
          `RTHS_OFS_RUN_SPD: s_d.prdata = {12'h000, cfg.run_spd};
          `RTHS_OFS_ACCEL: s_d.prdata = {12'h000, cfg.accel};
          `RTHS_OFS_START_SPD: s_d.prdata = {12'h000, cfg.start_spd};
          `RTHS_OFS_OFFSET: s_d.prdata = {{8{cfg.offset[23]}}, cfg.offset};
          `RTHS_OFS_PRESET: s_d.prdata = {{8{cfg.preset[23]}}, cfg.preset};
          `RTHS_OFS_PUSH_CUR: s_d.prdata = {22'h000000, cfg.push_cur};
          `RTHS_OFS_STATUS: s_d.prdata = {29'h00000000, s_q.stat.home_done, s_q.stat.moving, s_q.stat.ready};
          `RTHS_OFS_CMD_POS: s_d.prdata = {{8{s_q.cmd_pos[23]}}, s_q.cmd_pos};
          `RTHS_OFS_APPROACH: s_d.prdata = {12'h000, approach};
          default: s_d.pslverr = 1'b1;
        endcase
      end
    end

    unique case (s_q.st)
      rths_pkg::RTHS_IDLE: begin
        if (home_req && s_q.stat.ready) begin // RL16
          s_d.stat.ready = 1'b0;
          s_d.stat.moving = 1'b1;
          s_d.stat.home_done = 1'b0;
          s_d.motion.run = 1'b1;
          s_d.motion.dir_pos = cfg.dir_pos; // RL10
          s_d.motion.by_steps = 1'b0;
          s_d.motion.steps = 24'h000000;
          s_d.motion.push = (cfg.mode == `RTHS_MODE_PUSH);
          // three-sensor seeks fast, the others creep at start speed
          s_d.motion.speed = (cfg.mode == `RTHS_MODE_THREE) ? cfg.run_spd : cfg.start_spd; // RL21 RL5
          s_d.st = rths_pkg::RTHS_SEEK;
        end
      end
      rths_pkg::RTHS_SEEK: begin
        if (cfg.mode == `RTHS_MODE_THREE) begin
          if (limit_hit) begin
            s_d.motion.dir_pos = !s_q.motion.dir_pos;
          end
          else if (origin_rise) begin
            s_d.motion.speed = approach; // RL23
            if (cfg.qualify_in_a_en || cfg.tim_en) begin
              s_d.st = rths_pkg::RTHS_QUAL; // RL20
            end
            else begin
              s_d.motion.run = 1'b0; // RL21
              s_d.st = rths_pkg::RTHS_OFFSET;
            end
          end
        end
        else if ((cfg.mode == `RTHS_MODE_TWO && limit_hit) || (cfg.mode == `RTHS_MODE_PUSH && push_stall)) begin
          s_d.motion.dir_pos = !s_q.motion.dir_pos; // RL22
          s_d.motion.push = 1'b0;
          s_d.motion.speed = approach;
          s_d.st = rths_pkg::RTHS_ESCAPE;
        end
      end
      rths_pkg::RTHS_QUAL: begin
        if (qual_hit) begin
          s_d.motion.run = 1'b0; // RL20
          s_d.st = rths_pkg::RTHS_OFFSET;
        end
        else if (!origin_sensor_in) begin
          // sensor left without a qualifier: keep seeking for the next edge
          s_d.st = rths_pkg::RTHS_SEEK;
        end
      end
      rths_pkg::RTHS_ESCAPE: begin
        // push mode has no sensor to leave, so it starts the walk at once
        if (cfg.mode == `RTHS_MODE_PUSH || !(negative_limit_sensor || positive_limit_sensor)) begin
          s_d.motion.by_steps = 1'b1;
          s_d.motion.steps = `RTHS_ESCAPE_STEPS; // RL22
          s_d.st = rths_pkg::RTHS_WALK;
        end
      end
      rths_pkg::RTHS_WALK: begin
        if (motion_done) begin
          s_d.motion.run = 1'b0;
          s_d.motion.by_steps = 1'b0;
          s_d.st = rths_pkg::RTHS_OFFSET;
        end
      end
      rths_pkg::RTHS_OFFSET: begin
        if (!s_q.motion.run) begin
          if (cfg.offset == 24'h000000) begin
            s_d.st = rths_pkg::RTHS_DONE; // RL2
          end
          else begin
            s_d.motion.run = 1'b1; // RL1
            s_d.motion.by_steps = 1'b1;
            s_d.motion.dir_pos = !cfg.offset[23];
            s_d.motion.steps = cfg.offset[23] ? 24'(-cfg.offset) : cfg.offset;
            s_d.motion.speed = cfg.run_spd;
          end
        end
        else if (motion_done) begin
          s_d.motion.run = 1'b0;
          s_d.motion.by_steps = 1'b0;
          s_d.st = rths_pkg::RTHS_DONE;
        end
      end
      rths_pkg::RTHS_DONE: begin
        s_d.cmd_pos = 24'h000000; // RL3
        s_d.stat.home_done = 1'b1; // RL18
        s_d.stat.ready = 1'b1; // RL24
        s_d.stat.moving = 1'b0;
        s_d.st = rths_pkg::RTHS_IDLE;
      end
      default: s_d.st = rths_pkg::RTHS_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q.st <= rths_pkg::RTHS_IDLE;
      s_q.stat.ready <= 1'b1;
      s_q.stat.moving <= 1'b0;
      s_q.stat.home_done <= 1'b0;
      s_q.motion <= '0;
      s_q.cmd_pos <= 24'h000000;
      s_q.prdata <= 32'h00000000;
      s_q.pready <= 1'b0;
      s_q.pslverr <= 1'b0;
      s_q.origin_prev <= 1'b0;
      s_q.push_current <= `RTHS_RST_PUSH_CUR;
      s_q.accel_rate <= `RTHS_RST_ACCEL;
    end
    else begin
      s_q <= s_d;
    end
  end

  assign prdata = s_q.prdata;
  assign pready = s_q.pready;
  assign pslverr = s_q.pslverr;
  assign ready = s_q.stat.ready;
  assign moving = s_q.stat.moving;
  assign home_done = s_q.stat.home_done;
  assign motion = s_q.motion;
  assign push_current = s_q.push_current;
  assign accel_rate = s_q.accel_rate;
  assign cmd_pos = s_q.cmd_pos;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_start;
    @(posedge pclk) disable iff (!presetn)
    (s_q.st == rths_pkg::RTHS_IDLE && home_req && ready)
      |=> (!ready && moving && motion.run && motion.dir_pos == $past(cfg.dir_pos));
  endproperty
  a_start: assert property (p_start) else $error("homing did not start"); // RL16 RL10

  property p_done;
    @(posedge pclk) disable iff (!presetn)
    (s_q.st == rths_pkg::RTHS_DONE) |=> (home_done && ready && !moving && cmd_pos == 24'h000000);
  endproperty
  a_done: assert property (p_done) else $error("completion outputs wrong"); // RL18 RL24 RL3

  property p_zero_off;
    @(posedge pclk) disable iff (!presetn)
    (s_q.st == rths_pkg::RTHS_OFFSET && !motion.run && cfg.offset == 24'h000000) |=> s_q.st == rths_pkg::RTHS_DONE;
  endproperty
  a_zero_off: assert property (p_zero_off) else $error("zero offset moved"); // RL2

  property p_off_move;
    @(posedge pclk) disable iff (!presetn)
    (s_q.st == rths_pkg::RTHS_OFFSET && !motion.run && cfg.offset != 24'h000000) |=> (motion.run && motion.by_steps);
  endproperty
  a_off_move: assert property (p_off_move) else $error("offset move missing"); // RL1

  property p_approach;
    @(posedge pclk) disable iff (!presetn)
    (s_q.st == rths_pkg::RTHS_ESCAPE || s_q.st == rths_pkg::RTHS_QUAL)
      |-> ((motion.speed == cfg.start_spd && cfg.start_spd < `RTHS_APPROACH_CAP)
      || (motion.speed == `RTHS_APPROACH_CAP && cfg.start_spd >= `RTHS_APPROACH_CAP));
  endproperty
  a_approach: assert property (p_approach) else $error("approach speed wrong"); // RL23

  property p_walk;
    @(posedge pclk) disable iff (!presetn)
    (s_q.st == rths_pkg::RTHS_WALK) |-> (motion.steps == `RTHS_ESCAPE_STEPS);
  endproperty
  a_walk: assert property (p_walk) else $error("escape walk not 200 steps"); // RL22

  property p_qual;
    @(posedge pclk) disable iff (!presetn)
    (s_q.st == rths_pkg::RTHS_QUAL && !origin_sensor_in) |=> s_q.st != rths_pkg::RTHS_OFFSET;
  endproperty
  a_qual: assert property (p_qual) else $error("qualified without sensor"); // RL20

  property p_busy;
    @(posedge pclk) disable iff (!presetn)
    (s_q.st != rths_pkg::RTHS_IDLE) |-> !ready;
  endproperty
  a_busy: assert property (p_busy) else $error("ready while homing"); // RL24

  property p_seek_speed;
    @(posedge pclk) disable iff (!presetn)
    (s_q.st == rths_pkg::RTHS_IDLE && home_req && ready && cfg.mode == `RTHS_MODE_THREE)
      |=> motion.speed == $past(cfg.run_spd);
  endproperty
  a_seek_speed: assert property (p_seek_speed) else $error("seek speed not run speed"); // RL21

  property p_preset;
    @(posedge pclk) disable iff (!presetn)
    (psel && penable && pwrite && !pready && ready && paddr == `RTHS_OFS_CTRL && pwdata[`RTHS_CTRL_PRESET_BIT])
      |=> (cmd_pos == $past(cfg.preset) && pready && !pslverr);
  endproperty
  a_preset: assert property (p_preset) else $error("preset position not loaded"); // RL4

  // the copies trail the configuration store by exactly one cycle
  property p_mirror;
    @(posedge pclk) disable iff (!presetn)
    (push_current == $past(cfg.push_cur)) && (accel_rate == $past(cfg.accel));
  endproperty
  a_mirror: assert property (p_mirror) else $error("current or rate copy stale"); // RL13 RL7
endmodule

// >>> bench/rths_motion_model.sv
`timescale 1ns/1ps
// ----
// far-side motion generator: step moves end lat+1 cycles after they are commanded
// ----
module rths_motion_model (
  input wire logic pclk,
  input wire logic presetn,
  input rths_pkg::rths_motion_s motion,
  input wire logic [7:0] lat,
  output logic motion_done,
  output logic push_stall
);
  logic [7:0] cnt;
  logic [7:0] pcnt;
  // a move that stays commanded is treated as a new move of the same length
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 8'h00;
      pcnt <= 8'h00;
      motion_done <= 1'b0;
      push_stall <= 1'b0;
    end else begin
      if (motion.run && motion.by_steps && cnt >= lat) begin
        cnt <= 8'h00;
        motion_done <= 1'b1;
      end else begin
        cnt <= (motion.run && motion.by_steps) ? cnt + 8'h01 : 8'h00;
        motion_done <= 1'b0;
      end
      pcnt <= (motion.run && motion.push) ? pcnt + {7'h00, pcnt < lat} : 8'h00;
      push_stall <= motion.run && motion.push && pcnt >= lat;
    end
  end
endmodule

// >>> bench/test_return_to_home_sequencer.sv
`timescale 1ns/1ps
`include "rths_consts.svh"
module test_return_to_home_sequencer;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, home_req, origin_sensor_in, qualify_in_a;
  logic step_timing_signal, negative_limit_sensor, positive_limit_sensor, push_stall, motion_done;
  logic ready, moving, home_done, e, last_dir;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  rths_pkg::rths_motion_s motion;
  logic [9:0] push_current;
  logic [19:0] accel_rate, s;
  logic [23:0] cmd_pos, last_steps, pv;
  logic [7:0] lat;
  int n_fail, checks, cyc, n_moves;
  logic [11:0] bad_a [7] = '{`RTHS_OFS_RUN_SPD, `RTHS_OFS_RUN_SPD, `RTHS_OFS_ACCEL, `RTHS_OFS_START_SPD,
    `RTHS_OFS_MODE, `RTHS_OFS_PUSH_CUR, 12'h030};
  logic [31:0] bad_d [7] = '{32'h0, 32'h000F4241, 32'h0, 32'h000F4241, 32'h3, 32'h3E9, 32'h1};

  rths_top rths_top_inst(.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .home_req, .origin_sensor_in, .qualify_in_a, .step_timing_signal, .negative_limit_sensor,
    .positive_limit_sensor, .push_stall, .motion_done, .ready, .moving, .home_done, .motion, .push_current,
    .accel_rate, .cmd_pos);
  rths_motion_model rths_motion_model_inst(.pclk, .presetn, .motion, .lat, .motion_done, .push_stall);

  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    cyc++;
    if (motion_done === 1'b1) begin
      n_moves++;
      last_steps = motion.steps;
      last_dir = motion.dir_pos;
    end
    if (cyc == 20000) begin
      n_fail++;
      close_out();
    end
  end

  // ----
  // helpers
  // ----
  function automatic logic [31:0] approach(input logic [19:0] v);
    return (v < 20'h001F4) ? {12'h000, v} : 32'h000001F4;
  endfunction

  task automatic chk_val(input string nm, input logic [31:0] x, input logic [31:0] g);
    checks++;
    if (g !== x) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, x, g);
    end
  endtask

  task automatic chk_bit(input string nm, input logic x, input logic g);
    chk_val(nm, {31'h0, x}, {31'h0, g});
  endtask

  // values are taken at the edge where pready is seen high, then released
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r,
    output logic er);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    chk_bit("pready", 1'b1, pready);
    r = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic xe);
    apb(1'b1, a, d, q, e);
    chk_bit("pslverr", xe, e);
  endtask

  task automatic rd_chk(input string nm, input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0, q, e);
    chk_bit("pslverr", 1'b0, e);
    chk_val(nm, x, q);
  endtask

  task automatic wait_ready(input logic lvl, input int lim);
    int k;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (ready !== lvl && k < lim);
    chk_bit("ready", lvl, ready);
  endtask

  task automatic home(input logic [1:0] md, input int qual, input logic dir, input logic [23:0] off);
    logic [19:0] rs;
    int k, m0;
    rs = 20'h00001 + 20'($urandom % 1000000);
    m0 = n_moves;
    lat <= ($urandom % 2) ? 8'h01 : 8'h19;
    wr(`RTHS_OFS_MODE, {30'h0, md}, 1'b0);
    wr(`RTHS_OFS_CTRL, {29'h0, qual == 2, qual == 1, dir}, 1'b0);
    wr(`RTHS_OFS_OFFSET, {8'h00, off}, 1'b0);
    wr(`RTHS_OFS_RUN_SPD, {12'h000, rs}, 1'b0);
    chk_bit("ready", 1'b1, ready);
    home_req <= 1'b1;
    wait_ready(1'b0, 20);
    chk_bit("moving", 1'b1, moving);
    chk_bit("run", 1'b1, motion.run);
    chk_bit("dir", dir, motion.dir_pos);
    home_req <= 1'b0;
    wr(`RTHS_OFS_MODE, 32'h0, 1'b1);
    if (md == 2'h1) begin
      chk_val("speed", {12'h0, rs}, {12'h0, motion.speed});
      origin_sensor_in <= 1'b1;
      if (qual != 0) begin
        repeat (10) @(posedge pclk);
        chk_bit("ready", 1'b0, ready);
        origin_sensor_in <= 1'b0;
        if (qual == 1) qualify_in_a <= 1'b1;
        else step_timing_signal <= 1'b1;
        repeat (4) @(posedge pclk);
        chk_bit("ready", 1'b0, ready);
        origin_sensor_in <= 1'b1;
      end
    end else if (md == 2'h0) begin
      if (dir) positive_limit_sensor <= 1'b1;
      else negative_limit_sensor <= 1'b1;
      k = 0;
      do begin
        @(posedge pclk);
        k++;
      end while (motion.dir_pos === dir && k < 50);
      chk_bit("reverse", ~dir, motion.dir_pos);
      positive_limit_sensor <= 1'b0;
      negative_limit_sensor <= 1'b0;
    end
    wait_ready(1'b1, 400);
    chk_bit("moving", 1'b0, moving);
    chk_bit("home_done", 1'b1, home_done);
    chk_val("cmd_pos", 32'h0, {8'h0, cmd_pos});
    chk_val("moves", {31'h0, md != 2'h1} + {31'h0, off != 24'h0}, 32'(n_moves - m0));
    if (off != 24'h0) begin
      chk_val("offset", {8'h0, off[23] ? -off : off}, {8'h0, last_steps});
      chk_bit("offset_dir", ~off[23], last_dir);
    end else if (md != 2'h1) chk_val("escape", 32'h000000C8, {8'h0, last_steps});
    origin_sensor_in <= 1'b0;
    qualify_in_a <= 1'b0;
    step_timing_signal <= 1'b0;
  endtask

  task automatic close_out();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // ----
  // main sequence
  // ----
  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, home_req, origin_sensor_in, qualify_in_a} = 6'h00;
    {step_timing_signal, negative_limit_sensor, positive_limit_sensor} = 3'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    lat = 8'h01;
    {n_fail, checks, cyc, n_moves} = 128'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    void'($urandom(23041));
    chk_bit("ready", 1'b1, ready);
    chk_bit("home_done", 1'b0, home_done);
    chk_val("push_current", 32'h3E8, {22'h0, push_current});
    chk_val("accel_rate", 32'h3E8, {12'h0, accel_rate});
    rd_chk("run_spd", `RTHS_OFS_RUN_SPD, 32'h3E8);
    rd_chk("start_spd", `RTHS_OFS_START_SPD, 32'h1F4);
    rd_chk("offset", `RTHS_OFS_OFFSET, 32'h0);
    rd_chk("push_cur", `RTHS_OFS_PUSH_CUR, 32'h3E8);
    rd_chk("approach", `RTHS_OFS_APPROACH, 32'h1F4);
    apb(1'b0, `RTHS_OFS_CTRL, 32'h0, q, e);
    chk_val("ctrl", 32'h1, {29'h0, q[2:0]});
    for (int i = 0; i < 7; i++) wr(bad_a[i], bad_d[i], 1'b1);
    apb(1'b0, 12'h030, 32'h0, q, e);
    chk_bit("pslverr", 1'b1, e);
    chk_val("unmapped", 32'h0, q);
    wr(`RTHS_OFS_RUN_SPD, 32'h000F4240, 1'b0);
    rd_chk("run_spd", `RTHS_OFS_RUN_SPD, 32'h000F4240);
    wr(`RTHS_OFS_ACCEL, 32'h1, 1'b0);
    @(posedge pclk);
    chk_val("accel_rate", 32'h1, {12'h0, accel_rate});
    wr(`RTHS_OFS_OFFSET, 32'h00800000, 1'b0);
    apb(1'b0, `RTHS_OFS_OFFSET, 32'h0, q, e);
    chk_val("offset", 32'h00800000, {8'h0, q[23:0]});
    for (int i = 0; i < 5; i++) begin
      s = (i == 0) ? 20'h001F3 : (i == 1) ? 20'h001F4 : 20'h00001 + 20'($urandom % 1000);
      wr(`RTHS_OFS_START_SPD, {12'h0, s}, 1'b0);
      rd_chk("approach", `RTHS_OFS_APPROACH, approach(s));
    end
    s = 20'($urandom % 1001);
    wr(`RTHS_OFS_PUSH_CUR, {12'h0, s}, 1'b0);
    @(posedge pclk);
    chk_val("push_current", {12'h0, s}, {22'h0, push_current});
    home(2'h1, 0, 1'b1, 24'h000000);
    home(2'h1, 1, 1'b0, 24'hFFFF9C);
    home(2'h1, 2, 1'b1, 24'h000000);
    home(2'h0, 0, 1'b1, 24'h000000);
    home(2'h0, 0, 1'b0, 24'h000001 + 24'($urandom % 1000));
    home(2'h2, 0, 1'b1, 24'h000000);
    pv = 24'($urandom);
    s = 20'(n_moves);
    wr(`RTHS_OFS_PRESET, {8'h0, pv}, 1'b0);
    wr(`RTHS_OFS_CTRL, 32'h9, 1'b0);
    repeat (3) @(posedge pclk);
    chk_val("cmd_pos", {8'h0, pv}, {8'h0, cmd_pos});
    chk_val("moves", {12'h0, s}, 32'(n_moves));
    chk_bit("home_done", 1'b1, home_done);
    close_out();
  end
endmodule
